// >>> hw/interrupt_entry_return_sequencer.v
// Purpose: interrupt request gating, priority check and fixed entry and return sequencing
// Assumes: one aclk cycle is one instruction cycle; core answers fetch and pop in the same cycle
// Notes: registers over AXI4-Lite; one write and one read outstanding at most
`timescale 1ns/10ps
`include "intc_map.vh"
module interrupt_entry_return_sequencer (
	input  wire                 aclk,
	input  wire                 aresetn,
	input  wire [31:0]          awaddr,
	input  wire                 awvalid,
	output reg                  awready,
	input  wire [31:0]          wdata,
	input  wire [3:0]           wstrb,
	input  wire                 wvalid,
	output reg                  wready,
	output reg  [1:0]           bresp,
	output reg                  bvalid,
	input  wire                 bready,
	input  wire [31:0]          araddr,
	input  wire                 arvalid,
	output reg                  arready,
	output reg  [31:0]          rdata,
	output reg  [1:0]           rresp,
	output reg                  rvalid,
	input  wire                 rready,
	input  wire [`NUM_SRC-1:0]  src_event,
	input  wire [`NUM_EXT-1:0]  ext_irq_in,
	input  wire                 insn_two_cycle,
	input  wire                 latency_adder,
	input  wire                 return_from_interrupt_op,
	input  wire [23:0]          cpu_pc,
	input  wire [23:0]          fetch_data,
	input  wire [15:0]          pop_data,
	output reg                  pc_load,
	output reg  [23:0]          pc_value,
	output reg                  exec_nop,
	output reg                  vector_fetch,
	output reg  [23:0]          vector_addr,
	output reg                  stack_push,
	output reg  [15:0]          push_data,
	output reg                  stack_pop,
	output reg                  resume
);
	localparam S_IDLE  = 4'h0;
	localparam S_STALL = 4'h1;
	localparam S_E2    = 4'h2;
	localparam S_E3    = 4'h3;
	localparam S_E4    = 4'h4;
	localparam S_R1    = 4'h5;
	localparam S_R2    = 4'h6;
	localparam S_R3    = 4'h7;
	localparam S_R4    = 4'h8;

	reg  [31:0]                 global_int_control_one_ff;
	reg  [31:0]                 global_int_control_two_ff;
	reg  [`NUM_SRC-1:0]         source_enable_regs_ff;
	reg  [`NUM_SRC*`PRIO_W-1:0] source_priority_regs_ff;
	reg  [7:0]                  status_low_byte_ff;
	reg                         cpu_priority_top_bit_ff;
	reg  [6:0]                  pending_vector_number_ff;
	reg  [3:0]                  pending_level_ff;
	reg                         prio_lock_ff;
	reg  [`NUM_EXT-1:0]         ext_prev_ff;
	reg  [3:0]                  state_ff;
	reg                         two_cyc_ff;
	reg  [23:0]                 temp_pc_ff;
	reg  [7:0]                  temp_srl_ff;
	reg  [15:0]                 ret_high_ff;
	reg                         aw_hold_ff;
	reg                         w_hold_ff;
	reg  [31:0]                 awaddr_ff;
	reg  [31:0]                 wdata_ff;
	reg  [3:0]                  wstrb_ff;

	wire [`NUM_SRC-1:0]         request_flag_regs;
	wire [`NUM_SRC-1:0]         flag_set;
	wire [`NUM_SRC-1:0]         flag_clr;
	wire [`NUM_EXT-1:0]         ext_edge;
	wire [2:0]                  cpu_priority_field;
	wire                        nesting_disable;
	wire                        alternate_table_select;
	wire                        req_valid;
	wire [3:0]                  req_src;
	wire [2:0]                  req_prio;
	wire [31:0]                 prio_lo_word;
	wire [31:0]                 prio_hi_word;
	wire [23:0]                 table_base;
	wire [23:0]                 vec_addr;
	wire                        aw_fire;
	wire                        w_fire;
	wire                        ar_fire;
	wire                        do_write;
	wire                        aw_busy_nxt;
	wire                        w_busy_nxt;
	wire                        b_busy_nxt;
	wire [31:0]                 wmask;
	wire [32:0]                 wr_lookup;
	wire [32:0]                 rd_lookup;
	wire [31:0]                 merged;
	wire                        wr_status;
	wire                        hw_level_write;

	assign cpu_priority_field     = status_low_byte_ff[`CPL_MSB:`CPL_LSB];
	assign nesting_disable        = global_int_control_one_ff[`NEST_DIS_BIT];
	assign alternate_table_select = global_int_control_two_ff[`ALT_SEL_BIT];

	// external pins: polarity bit set means falling edge
	genvar g;
	generate
		for (g = 0; g < `NUM_EXT; g = g + 1) begin : g_ext
			assign ext_edge[g] = global_int_control_two_ff[g] ? (ext_prev_ff[g] & ~ext_irq_in[g]) :
			                                                    (~ext_prev_ff[g] & ext_irq_in[g]);
		end
		for (g = 0; g < 8; g = g + 1) begin : g_prio_word
			assign prio_lo_word[g*4 +: 4] = {1'b0, source_priority_regs_ff[g*3 +: 3]};
			assign prio_hi_word[g*4 +: 4] = {1'b0, source_priority_regs_ff[(g+8)*3 +: 3]};
		end
	endgenerate

	assign flag_set = src_event | {{(`NUM_SRC-`NUM_EXT){1'b0}}, ext_edge};

	function [32:0] reg_read;
		input [31:0] a;
		begin
			if (a == `ADDR_GLOBAL_ONE) begin
				reg_read = {1'b1, global_int_control_one_ff};
			end else if (a == `ADDR_GLOBAL_TWO) begin
				reg_read = {1'b1, global_int_control_two_ff};
			end else if (a == `ADDR_FLAGS) begin
				reg_read = {1'b1, 16'h0000, request_flag_regs};
			end else if (a == `ADDR_ENABLES) begin
				reg_read = {1'b1, 16'h0000, source_enable_regs_ff};
			end else if (a == `ADDR_PRIO_LO) begin
				reg_read = {1'b1, prio_lo_word};
			end else if (a == `ADDR_PRIO_HI) begin
				reg_read = {1'b1, prio_hi_word};
			end else if (a == `ADDR_STATUS) begin
				reg_read = {1'b1, 24'h000000, status_low_byte_ff};
			end else if (a == `ADDR_CORE) begin
				reg_read = {1'b1, 28'h0000000, cpu_priority_top_bit_ff, 3'h0};
			end else if (a == `ADDR_PEND_VEC) begin
				reg_read = {1'b1, 25'h0000000, pending_vector_number_ff};
			end else if (a == `ADDR_PEND_LVL) begin
				reg_read = {1'b1, 28'h0000000, pending_level_ff};
			end else begin
				reg_read = 33'h000000000;
			end
		end
	endfunction

	assign aw_fire     = awvalid & awready;
	assign w_fire      = wvalid & wready;
	assign ar_fire     = arvalid & arready;
	assign do_write    = aw_hold_ff & w_hold_ff & ~bvalid;
	assign aw_busy_nxt = (aw_hold_ff | aw_fire) & ~do_write;
	assign w_busy_nxt  = (w_hold_ff | w_fire) & ~do_write;
	assign b_busy_nxt  = do_write | (bvalid & ~bready);
	assign wmask       = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	assign wr_lookup   = reg_read(awaddr_ff);
	assign rd_lookup   = reg_read(araddr);
	assign merged      = (wr_lookup[31:0] & ~wmask) | (wdata_ff & wmask);
	assign wr_status   = do_write && (awaddr_ff == `ADDR_STATUS);
	// writing a one to a flag bit clears it
	assign flag_clr    = (do_write && (awaddr_ff == `ADDR_FLAGS)) ? (wdata_ff[15:0] & wmask[15:0]) : 16'h0000;
	assign hw_level_write = (state_ff == S_E3) || (state_ff == S_R1);

	assign table_base = alternate_table_select ? `ALT_TABLE_BASE : `DEF_TABLE_BASE;
	assign vec_addr   = table_base + {16'h0000, pending_vector_number_ff, 1'b0};

	request_flags u_flags (
		.aclk    (aclk),
		.aresetn (aresetn),
		.set_in  (flag_set),
		.clr_in  (flag_clr),
		.flags   (request_flag_regs)
	);

	priority_resolver u_resolve (
		.pend      (request_flag_regs),
		.en        (source_enable_regs_ff),
		.prio      (source_priority_regs_ff),
		.level     ({cpu_priority_top_bit_ff, cpu_priority_field}),
		.req_valid (req_valid),
		.req_src   (req_src),
		.req_prio  (req_prio)
	);

	// bus slave handshakes
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awaddr_ff  <= 32'h00000000;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
			awready    <= 1'b0;
			wready     <= 1'b0;
			bvalid     <= 1'b0;
			bresp      <= `RESP_OKAY;
			arready    <= 1'b0;
			rvalid     <= 1'b0;
			rdata      <= 32'h00000000;
			rresp      <= `RESP_OKAY;
		end else begin
			if (do_write) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff  <= 1'b0;
				bvalid     <= 1'b1;
				bresp      <= wr_lookup[32] ? `RESP_OKAY : `RESP_SLVERR;
			end else begin
				if (aw_fire) begin
					aw_hold_ff <= 1'b1;
					awaddr_ff  <= awaddr;
				end
				if (w_fire) begin
					w_hold_ff <= 1'b1;
					wdata_ff  <= wdata;
					wstrb_ff  <= wstrb;
				end
				if (bvalid && bready) begin
					bvalid <= 1'b0;
				end
			end
			awready <= ~aw_busy_nxt & ~b_busy_nxt;
			wready  <= ~w_busy_nxt & ~b_busy_nxt;
			if (ar_fire) begin
				rvalid <= 1'b1;
				rdata  <= rd_lookup[31:0];
				rresp  <= rd_lookup[32] ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
			arready <= ~(ar_fire | (rvalid & ~rready));
		end
	end

	// software-owned configuration
	integer i;
	always @(posedge aclk) begin
		if (!aresetn) begin
			global_int_control_one_ff <= `GLOBAL_ONE_RESET;
			global_int_control_two_ff <= `GLOBAL_TWO_RESET;
			source_enable_regs_ff     <= 16'h0000;
			source_priority_regs_ff   <= 48'h000000000000;
			ext_prev_ff               <= 3'h0;
		end else begin
			ext_prev_ff <= ext_irq_in;
			if (do_write && (awaddr_ff == `ADDR_GLOBAL_ONE)) begin
				global_int_control_one_ff <= merged & `GLOBAL_ONE_MASK;
			end else if (do_write && (awaddr_ff == `ADDR_GLOBAL_TWO)) begin
				global_int_control_two_ff <= merged & `GLOBAL_TWO_MASK;
			end else if (do_write && (awaddr_ff == `ADDR_ENABLES)) begin
				source_enable_regs_ff <= merged[15:0];
			end else if (do_write && (awaddr_ff == `ADDR_PRIO_LO)) begin
				for (i = 0; i < 8; i = i + 1) begin
					source_priority_regs_ff[i*3 +: 3] <= merged[i*4 +: 3];
				end
			end else if (do_write && (awaddr_ff == `ADDR_PRIO_HI)) begin
				for (i = 0; i < 8; i = i + 1) begin
					source_priority_regs_ff[(i+8)*3 +: 3] <= merged[i*4 +: 3];
				end
			end
		end
	end

	// cpu level: entry and return updates win over a software write in the same cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			status_low_byte_ff      <= 8'h00;
			cpu_priority_top_bit_ff <= 1'b0;
			prio_lock_ff            <= 1'b0;
		end else begin
			// no software path reaches the top bit, so traps stay unmaskable
			cpu_priority_top_bit_ff <= cpu_priority_top_bit_ff;
			if (state_ff == S_E3) begin
				status_low_byte_ff[`CPL_MSB:`CPL_LSB] <= nesting_disable ? `NEST_FORCE_LEVEL :
				                                                           pending_level_ff[2:0];
				prio_lock_ff <= nesting_disable;
			end else if (state_ff == S_R1) begin
				status_low_byte_ff <= pop_data[15:8];
			end else if (wr_status) begin
				status_low_byte_ff[4:0] <= merged[4:0];
				if (!prio_lock_ff) begin
					status_low_byte_ff[`CPL_MSB:`CPL_LSB] <= merged[`CPL_MSB:`CPL_LSB];
				end
			end
			if (state_ff == S_R3) begin
				prio_lock_ff <= 1'b0;
			end
		end
	end

	// entry and return sequencer; outputs are set on the edge entering the cycle they mark
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff                 <= S_IDLE;
			two_cyc_ff               <= 1'b0;
			temp_pc_ff               <= 24'h000000;
			temp_srl_ff              <= 8'h00;
			ret_high_ff              <= 16'h0000;
			pending_vector_number_ff <= 7'h00;
			pending_level_ff         <= 4'h0;
			pc_load                  <= 1'b0;
			pc_value                 <= 24'h000000;
			exec_nop                 <= 1'b0;
			vector_fetch             <= 1'b0;
			vector_addr              <= 24'h000000;
			stack_push               <= 1'b0;
			push_data                <= 16'h0000;
			stack_pop                <= 1'b0;
			resume                   <= 1'b0;
		end else begin
			pc_load      <= 1'b0;
			exec_nop     <= 1'b0;
			vector_fetch <= 1'b0;
			stack_push   <= 1'b0;
			stack_pop    <= 1'b0;
			resume       <= 1'b0;
			case (state_ff)
			S_IDLE: begin
				if (return_from_interrupt_op) begin
					state_ff  <= S_R1;
					stack_pop <= 1'b1;
				end else if (req_valid && !hw_level_write) begin
					// cycle one: the running instruction completes, nothing is aborted
					pending_vector_number_ff <= `VEC_FIRST + {3'h0, req_src};
					pending_level_ff         <= {1'b0, req_prio};
					two_cyc_ff               <= insn_two_cycle;
					if (latency_adder) begin
						state_ff <= S_STALL;
					end else begin
						state_ff    <= S_E2;
						temp_pc_ff  <= cpu_pc;
						temp_srl_ff <= status_low_byte_ff;
						exec_nop    <= ~insn_two_cycle;
					end
				end
			end
			S_STALL: begin
				state_ff    <= S_E2;
				temp_pc_ff  <= cpu_pc;
				temp_srl_ff <= status_low_byte_ff;
				exec_nop    <= ~two_cyc_ff;
			end
			S_E2: begin
				state_ff     <= S_E3;
				pc_load      <= 1'b1;
				pc_value     <= vec_addr;
				vector_fetch <= 1'b1;
				vector_addr  <= vec_addr;
				stack_push   <= 1'b1;
				push_data    <= temp_pc_ff[15:0];
			end
			S_E3: begin
				state_ff   <= S_E4;
				pc_load    <= 1'b1;
				pc_value   <= fetch_data;
				exec_nop   <= 1'b1;
				stack_push <= 1'b1;
				push_data  <= {temp_srl_ff, temp_pc_ff[23:16]};
			end
			S_E4: begin
				state_ff <= S_IDLE;
			end
			S_R1: begin
				state_ff    <= S_R2;
				stack_pop   <= 1'b1;
				ret_high_ff <= pop_data;
			end
			S_R2: begin
				state_ff <= S_R3;
				pc_load  <= 1'b1;
				pc_value <= {ret_high_ff[7:0], pop_data};
				exec_nop <= 1'b1;
			end
			S_R3: begin
				state_ff <= S_R4;
				resume   <= 1'b1;
			end
			S_R4: begin
				state_ff <= S_IDLE;
			end
			default: begin
				state_ff <= S_IDLE;
			end
			endcase
		end
	end
endmodule

// >>> hw/intc_map.vh
// Purpose: register map, field positions and fixed values of the interrupt sequencer
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: definitions only
`ifndef INTC_MAP_VH
`define INTC_MAP_VH

`define ADDR_GLOBAL_ONE   32'h00000000
`define ADDR_GLOBAL_TWO   32'h00000004
`define ADDR_FLAGS        32'h00000008
`define ADDR_ENABLES      32'h0000000c
`define ADDR_PRIO_LO      32'h00000010
`define ADDR_PRIO_HI      32'h00000014
`define ADDR_STATUS       32'h00000018
`define ADDR_CORE         32'h0000001c
`define ADDR_PEND_VEC     32'h00000020
`define ADDR_PEND_LVL     32'h00000024

`define NUM_SRC           16
`define NUM_EXT           3
`define PRIO_W            3
`define NEST_DIS_BIT      15
`define ALT_SEL_BIT       15
`define CPL_MSB           7
`define CPL_LSB           5
`define TOP_BIT           3
`define NEST_FORCE_LEVEL  3'h7
`define VEC_FIRST         7'h08
`define DEF_TABLE_BASE    24'h000000
`define ALT_TABLE_BASE    24'h000100

`define GLOBAL_ONE_MASK   32'h0000fffe
`define GLOBAL_TWO_MASK   32'h00008007
`define GLOBAL_ONE_RESET  32'h00000000
`define GLOBAL_TWO_RESET  32'h00000000

`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// >>> hw/request_flags.v
// Purpose: one sticky request flag per interrupt source
// Assumes: set_in and clr_in are one-cycle pulses synchronous to aclk
// Notes: hardware only sets, software only clears; a set beats a clear in the same cycle
`timescale 1ns/10ps
`include "intc_map.vh"
module request_flags (
	input  wire                  aclk,
	input  wire                  aresetn,
	input  wire [`NUM_SRC-1:0]   set_in,
	input  wire [`NUM_SRC-1:0]   clr_in,
	output wire [`NUM_SRC-1:0]   flags
);
	genvar i;
	generate
		for (i = 0; i < `NUM_SRC; i = i + 1) begin : g_flag
			reg flag_ff;
			always @(posedge aclk) begin
				if (!aresetn) begin
					flag_ff <= 1'b0;
				end else if (set_in[i]) begin
					flag_ff <= 1'b1;
				end else if (clr_in[i]) begin
					flag_ff <= 1'b0;
				end
			end
			assign flags[i] = flag_ff;
		end
	endgenerate
endmodule

// >>> hw/priority_resolver.v
// Purpose: pick the enabled pending source with the highest priority above the cpu level
// Assumes: priorities packed three bits per source, source 0 lowest
// Notes: purely combinational; ties go to the lowest source index
`timescale 1ns/10ps
`include "intc_map.vh"
module priority_resolver (
	input  wire [`NUM_SRC-1:0]          pend,
	input  wire [`NUM_SRC-1:0]          en,
	input  wire [`NUM_SRC*`PRIO_W-1:0]  prio,
	input  wire [3:0]                   level,
	output reg                          req_valid,
	output reg  [3:0]                   req_src,
	output reg  [`PRIO_W-1:0]           req_prio
);
	integer k;
	always @* begin
		req_valid = 1'b0;
		req_src   = 4'h0;
		req_prio  = 3'h0;
		// walking downward with >= lets the lower index win a tie
		for (k = `NUM_SRC - 1; k >= 0; k = k - 1) begin
			if (pend[k] && en[k] && ({1'b0, prio[k*3 +: 3]} > level) &&
			    (!req_valid || (prio[k*3 +: 3] >= req_prio))) begin
				req_valid = 1'b1;
				req_src   = k[3:0];
				req_prio  = prio[k*3 +: 3];
			end
		end
	end
endmodule

// >>> dv/core_stack_model.sv
// Purpose: core side model answering vector fetches, stack pushes and pops
// Assumes: answers come back in the same cycle as the strobe
// Notes: idle lines show an inverted pattern so a stale sample is caught
`timescale 1ns/10ps
module core_stack_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        vector_fetch,
	input  wire logic [23:0] vector_addr,
	input  wire logic        stack_push,
	input  wire logic [15:0] push_data,
	input  wire logic        stack_pop,
	output logic      [23:0] fetch_data,
	output logic      [15:0] pop_data
);
	logic [15:0] stack_ff [0:7];
	logic [2:0]  sp_ff;

	// routine address is a fixed offset from its slot, so every source differs
	assign fetch_data = vector_fetch ? vector_addr + 24'h002000 : ~vector_addr;
	assign pop_data   = stack_pop ? stack_ff[sp_ff - 3'h1] : ~push_data;

	always @(posedge aclk) begin
		if (!aresetn) begin
			sp_ff <= 3'h0;
		end else if (stack_push) begin
			stack_ff[sp_ff] <= push_data;
			sp_ff <= sp_ff + 3'h1;
		end else if (stack_pop) begin
			sp_ff <= sp_ff - 3'h1;
		end
	end
endmodule

// >>> dv/interrupt_entry_return_sequencer_assertions.sv
// Purpose: timing checks on the entry and return sequences
// Assumes: one aclk cycle per instruction cycle
// Notes: watches core side outputs and the fetch_data answer only
`timescale 1ns/10ps
module interrupt_entry_return_sequencer_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        pc_load,
	input wire logic [23:0] pc_value,
	input wire logic        exec_nop,
	input wire logic        vector_fetch,
	input wire logic [23:0] vector_addr,
	input wire logic [23:0] fetch_data,
	input wire logic        stack_push,
	input wire logic        stack_pop,
	input wire logic        resume
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_fetch_loads_pc: assert property (vector_fetch |-> pc_load && stack_push && pc_value == vector_addr)
		else $error("vector fetch without pc load and push");
	a_routine_load: assert property (vector_fetch |=> pc_load && exec_nop && stack_push && !vector_fetch
		&& pc_value == $past(fetch_data))
		else $error("routine address not loaded after fetch");
	a_entry_ends: assert property (vector_fetch |=> ##1 !pc_load && !stack_push && !exec_nop)
		else $error("entry runs past four cycles");
	a_nop_then_fetch: assert property (exec_nop && !pc_load |=> vector_fetch)
		else $error("saving nop not followed by vector fetch");
	a_pop_order: assert property ($rose(stack_pop) |=> stack_pop ##1
		(pc_load && exec_nop && !stack_pop) ##1 resume)
		else $error("return sequence out of order");
	a_pop_twice: assert property (stack_pop && $past(stack_pop) |=> !stack_pop)
		else $error("more than two pops");
	a_resume_alone: assert property (resume |-> !pc_load && !stack_pop && !vector_fetch && !stack_push)
		else $error("resume overlaps other core action");
	a_push_pair: assert property (stack_push |-> pc_load && !stack_pop)
		else $error("push outside entry load cycles");
	a_table_range: assert property (vector_fetch |-> vector_addr[0] == 1'b0
		&& vector_addr[23:9] == 15'h0000 && vector_addr[7:0] >= 8'h10 && vector_addr[7:0] <= 8'h2e)
		else $error("vector address outside tables");
endmodule

bind interrupt_entry_return_sequencer interrupt_entry_return_sequencer_assertions
	interrupt_entry_return_sequencer_assertions_inst (.aclk, .aresetn, .pc_load, .pc_value, .exec_nop,
	.vector_fetch, .vector_addr, .fetch_data, .stack_push, .stack_pop, .resume);

// >>> dv/interrupt_entry_return_sequencer_bench.sv
// Purpose: self-checking bench for the interrupt sequencer
// Assumes: core answers from core_stack_model, registers over AXI4-Lite
// Notes: external pin edges are checked with every source masked, so no entry follows them
`timescale 1ns/10ps
module interrupt_entry_return_sequencer_bench;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] awaddr, wdata, araddr;
	logic [3:0]  wstrb;
	logic [15:0] src_event;
	logic [2:0]  ext_irq_in;
	logic        insn_two_cycle, latency_adder, return_from_interrupt_op;
	logic [23:0] cpu_pc;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [23:0] fetch_data, pc_value, vector_addr;
	wire  [15:0] pop_data, push_data;
	wire         pc_load, exec_nop, vector_fetch, stack_push, stack_pop, resume;
	int          n_mismatch, checks_done, cyc;

	interrupt_entry_return_sequencer interrupt_entry_return_sequencer_inst (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .src_event, .ext_irq_in, .insn_two_cycle, .latency_adder,
		.return_from_interrupt_op, .cpu_pc, .fetch_data, .pop_data, .pc_load, .pc_value, .exec_nop,
		.vector_fetch, .vector_addr, .stack_push, .push_data, .stack_pop, .resume);
	core_stack_model core_stack_model_inst (.aclk, .aresetn, .vector_fetch, .vector_addr, .stack_push,
		.push_data, .stack_pop, .fetch_data, .pop_data);

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t seen %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, d, input logic [1:0] r = 2'b00);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk(bresp, r);
	endtask

	task automatic rc(input logic [31:0] a, e, input logic [1:0] r = 2'b00);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk(rdata, e);
		chk(rresp, r);
	endtask

	// drives the events in m and follows the entry cycle by cycle
	task automatic entry(input logic [15:0] m, input int s, input logic tw, ad,
		input logic [2:0] pr, nl, input logic [23:0] base);
		logic [7:0]  st;
		logic [23:0] va;
		int          vf;
		st = 8'h2b;
		vf = 0;
		va = base + 24'(2 * (8 + s));
		@(posedge aclk);
		insn_two_cycle <= tw;
		latency_adder <= ad;
		src_event <= m;
		for (int n = 1; n < 8; n++) begin
			@(posedge aclk);
			src_event <= 16'h0000;
			#1;
			if (n == 2) chk(exec_nop, !(tw | ad));
			if (vector_fetch) begin
				vf = n;
				chk(vector_addr, va);
				chk(push_data, cpu_pc[15:0]);
			end
			if (vf > 0 && n == vf + 1) begin
				chk({pc_load, exec_nop, pc_value}, {2'b11, va + 24'h002000});
				chk(push_data, {st, cpu_pc[23:16]});
			end
		end
		chk(vf, 3 + ad);
		rc(32'h08, m);
		rc(32'h20, 8 + s);
		rc(32'h24, pr);
		rc(32'h18, {nl, st[4:0]});
	endtask

	task automatic retn;
		@(posedge aclk);
		return_from_interrupt_op <= 1'b1;
		for (int n = 1; n < 5; n++) begin
			@(posedge aclk);
			return_from_interrupt_op <= 1'b0;
			#1;
			chk({stack_pop, pc_load, exec_nop, resume}, 4'(16'h1688 >> (4 * n - 4)));
			if (n == 3) chk(pc_value, cpu_pc);
		end
		rc(32'h18, 32'h2b);
	endtask

	// an event that must not start an entry
	task automatic quiet(input logic [15:0] m);
		logic seen;
		seen = 1'b0;
		@(posedge aclk);
		src_event <= m;
		repeat (8) begin
			@(posedge aclk);
			src_event <= 16'h0000;
			#1;
			seen = seen | vector_fetch;
		end
		chk(seen, 1'b0);
		wr(32'h08, {16'h0000, m});
	endtask

	// pin 0 edges of either polarity must set the flag of source 0
	task automatic ext_edges;
		@(posedge aclk);
		ext_irq_in <= 3'h1;
		rc(32'h08, 32'h1);
		wr(32'h08, 32'h1);
		wr(32'h04, 32'h1);
		ext_irq_in <= 3'h0;
		rc(32'h08, 32'h1);
		wr(32'h08, 32'h1);
		rc(32'h08, 32'h0);
		wr(32'h04, 32'h0);
	endtask

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, wdata, araddr, src_event, ext_irq_in} = 115'h0;
		{insn_two_cycle, latency_adder, return_from_interrupt_op} = 3'h0;
		wstrb = 4'hf;
		cpu_pc = 24'h9a5c36;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rc(32'h18, 32'h0);
		wr(32'h1c, 32'h8);
		rc(32'h1c, 32'h0);
		wr(32'h40, 32'h1, 2'b10);
		rc(32'h40, 32'h0, 2'b10);
		wr(32'h00, 32'hffffffff);
		rc(32'h00, 32'h0000fffe);
		wr(32'h04, 32'hffffffff);
		rc(32'h04, 32'h00008007);
		wr(32'h04, 32'h0);
		wr(32'h00, 32'h0);
		$display("registers test done");
		wr(32'h0c, 32'hffff);
		wr(32'h10, 32'h00300000);
		wr(32'h14, 32'h00040040);
		rc(32'h14, 32'h00040040);
		wr(32'h18, 32'h2b);
		for (int k = 0; k < 3; k++) begin
			entry(16'h0020, 5, k == 1, k == 2, 3'h3, 3'h3, 24'h0);
			wr(32'h08, 32'h20);
			retn();
		end
		$display("entry timing test done");
		entry(16'h1200, 9, 1'b0, 1'b0, 3'h4, 3'h4, 24'h0);
		wr(32'h08, 32'h1200);
		retn();
		wr(32'h04, 32'h8000);
		entry(16'h0020, 5, 1'b0, 1'b0, 3'h3, 3'h3, 24'h000100);
		wr(32'h08, 32'h20);
		retn();
		wr(32'h04, 32'h0);
		$display("tie and table test done");
		wr(32'h00, 32'h8000);
		entry(16'h0020, 5, 1'b0, 1'b0, 3'h3, 3'h7, 24'h0);
		wr(32'h18, 32'h0b);
		rc(32'h18, 32'heb);
		wr(32'h08, 32'h20);
		retn();
		wr(32'h18, 32'h6b);
		rc(32'h18, 32'h6b);
		wr(32'h00, 32'h0);
		quiet(16'h0020);
		wr(32'h18, 32'h2b);
		wr(32'h0c, 32'h0);
		quiet(16'h0020);
		ext_edges();
		$display("nesting and masking test done");
		complete_run();
	end
endmodule
